// *** design/act_seq_pkg.sv ***
// Shared constants and types for the card-side link activation sequencer
package act_seq_pkg;

  // Core clock rate used to turn times into cycle counts
  localparam int unsigned CORE_CLK_MHZ = 100;

  // Times as specified, in their own units
  localparam int unsigned CONTACT_RAISE_DELAY_US    = 1000;
  localparam int unsigned FIRST_RESUME_WINDOW_US    = 700;
  localparam int unsigned RESUME_WINDOW_FROM_OFF_US = 500;
  localparam int unsigned POWER_FRAME_REPLY_US      = 2000;
  localparam int unsigned SLAVE_DETECT_TIMEOUT_MS   = 100;

  // Longest times round down; the products here are exact
  localparam int unsigned FIRST_RESUME_CYC    = FIRST_RESUME_WINDOW_US * CORE_CLK_MHZ;
  localparam int unsigned RESUME_FROM_OFF_CYC = RESUME_WINDOW_FROM_OFF_US * CORE_CLK_MHZ;
  localparam int unsigned POWER_REPLY_CYC     = POWER_FRAME_REPLY_US * CORE_CLK_MHZ;
  localparam int unsigned SLAVE_DETECT_CYC    = SLAVE_DETECT_TIMEOUT_MS * 1000 * CORE_CLK_MHZ;

  // Activation frame kinds on the frame port
  localparam logic [1:0] FRAME_SYNC  = 2'h0;
  localparam logic [1:0] FRAME_POWER = 2'h1;
  localparam logic [1:0] FRAME_READY = 2'h2;

  // Reset values
  localparam logic [31:0] TIMER_RESET = 32'h0;
  localparam logic [1:0]  TYPE_RESET  = 2'h0;

  // Width of the timer
  localparam int unsigned TIMER_W = 32;

  // Activation sequencer states
  typedef enum logic [2:0]
  {
    ST_OFF         = 3'b000,
    ST_WAIT_RESUME = 3'b001,
    ST_WAIT_LINK   = 3'b010,
    ST_SEND        = 3'b011,
    ST_WAIT_ACK    = 3'b100,
    ST_LISTEN      = 3'b101,
    ST_INHIBIT     = 3'b110
  } act_state_e;

endpackage

// *** design/card_act_seq.sv ***
// Card-side activation sequencer for the single wire link, core and link domains
//
// Behaviour
// - Resume within 700 us, or 500 us
// - No link-on: drop current, then stay mute
// - Link on: send sync, await frontend frame
// - Repeat 1 resends last; 0 sends ready
// - Corrupted frontend frame gets no reply
// - Initial sync frames carry the info field
// - Rise from link-off reruns, without info field
// - Answer power frame within 2000 us
// - Current signal meaningless while voltage low
`timescale 1ns/10ps
module card_act_seq
  import act_seq_pkg::*;
#(
  parameter int unsigned FIRST_RESUME_LIMIT    = FIRST_RESUME_CYC,
  parameter int unsigned RESUME_FROM_OFF_LIMIT = RESUME_FROM_OFF_CYC,
  parameter int unsigned POWER_REPLY_LIMIT     = POWER_REPLY_CYC,
  parameter int unsigned SLAVE_DETECT_LIMIT    = SLAVE_DETECT_CYC
)
(
  // Core clock, reset and enable
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_core_en,
  // Pin levels, synchronised inside
  input  wire logic       i_supply_on,
  input  wire logic       i_master_voltage_signal,
  // Card status, core domain
  input  wire logic       i_card_ready,
  // Status, core domain
  output      logic       o_slave_current_signal,
  output      logic       o_inhibited,
  output      logic       o_reply_late,
  output      logic       o_subsequent,
  // Link clock and frame port, link domain
  input  wire logic       i_link_clk,
  input  wire logic       i_link_on,
  input  wire logic       i_rx_valid,
  input  wire logic       i_rx_ok,
  input  wire logic [1:0] i_rx_type,
  input  wire logic       i_rx_repeat_bit,
  input  wire logic       i_tx_done,
  output      logic       o_tx_start,
  output      logic [1:0] o_tx_type,
  output      logic       o_tx_with_info
);

  // Limits the timer cannot serve are refused; it saturates at the detect limit,
  // so no other limit may lie beyond it
  if (FIRST_RESUME_LIMIT == 0 || RESUME_FROM_OFF_LIMIT == 0 ||
      POWER_REPLY_LIMIT == 0 || SLAVE_DETECT_LIMIT == 0 ||
      FIRST_RESUME_LIMIT > SLAVE_DETECT_LIMIT ||
      RESUME_FROM_OFF_LIMIT > SLAVE_DETECT_LIMIT ||
      POWER_REPLY_LIMIT > SLAVE_DETECT_LIMIT)
  begin : g_bad_limit
    $error("card_act_seq: timing limits out of range");
  end

  act_state_e        state;
  logic [TIMER_W-1:0] timer;
  logic [1:0]        tx_type;
  logic [1:0]        last_type;
  logic              tx_with_info;
  logic              tx_tgl;
  logic              subsequent;
  logic              been_active;
  logic              ack_seen;
  logic              rx_seen;
  logic [4:0]        core_sync;
  logic              rx_tgl;
  logic              ack_tgl;
  logic              rx_ok_l;
  logic [1:0]        rx_type_l;
  logic              rx_repeat_l;
  logic              tx_sync;
  logic              tx_seen;
  logic              supply_s;
  logic              mv_s;
  logic              link_on_s;
  logic              rx_evt;
  logic              ack_evt;

  // Pins and link-domain toggles into the core domain
  level_sync #(.WIDTH(5)) u_core_sync
  (
    .i_clk    (i_core_clk),
    .i_arst_n (i_arst_n),
    .i_async  ({i_supply_on, i_master_voltage_signal, i_link_on, rx_tgl, ack_tgl}),
    .o_sync   (core_sync)
  );

  // Frame request toggle into the link domain
  level_sync #(.WIDTH(1)) u_link_sync
  (
    .i_clk    (i_link_clk),
    .i_arst_n (i_arst_n),
    .i_async  (tx_tgl),
    .o_sync   (tx_sync)
  );

  assign supply_s  = core_sync[4];
  assign mv_s      = core_sync[3];
  assign link_on_s = core_sync[2];
  assign rx_evt    = (core_sync[1] != rx_seen) && mv_s;
  assign ack_evt   = core_sync[0] != ack_seen;

  // Saturating limit test on the shared timer
  function automatic logic timer_at(input logic [TIMER_W-1:0] t, input int unsigned lim);
    timer_at = t >= lim[TIMER_W-1:0];
  endfunction

  // Event edge trackers follow the synchronised toggles
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rx_seen  <= 1'b0;
      ack_seen <= 1'b0;
    end
    else if (i_core_en)
    begin
      rx_seen  <= core_sync[1];
      ack_seen <= core_sync[0];
    end
  end

  // Activation sequence; a voltage drop aborts from any state
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state                  <= ST_OFF;
      timer                  <= TIMER_RESET;
      tx_type                <= TYPE_RESET;
      last_type              <= TYPE_RESET;
      tx_with_info           <= 1'b0;
      tx_tgl                 <= 1'b0;
      subsequent             <= 1'b0;
      been_active            <= 1'b0;
      o_slave_current_signal <= 1'b0;
      o_inhibited            <= 1'b0;
      o_reply_late           <= 1'b0;
    end
    else if (i_core_en)
    begin
      if (!timer_at(timer, SLAVE_DETECT_LIMIT))
        timer <= timer + 1'b1;
      if (!supply_s)
        been_active <= 1'b0;
      if (!mv_s || !supply_s)
      begin
        // Contact deactivated: release the wire and wait for the next rise
        state                  <= ST_OFF;
        o_slave_current_signal <= 1'b0;
        o_inhibited            <= 1'b0;
      end
      else
      begin
        case (state)
          ST_OFF:
          begin
            // A rise after an earlier activation is a subsequent one
            state        <= ST_WAIT_RESUME;
            subsequent   <= been_active;
            timer        <= TIMER_RESET;
            o_reply_late <= 1'b0;
          end
          ST_WAIT_RESUME:
          begin
            if (i_card_ready)
            begin
              o_slave_current_signal <= 1'b1;
              state                  <= ST_WAIT_LINK;
              timer                  <= TIMER_RESET;
            end
            else if (timer_at(timer, subsequent ? RESUME_FROM_OFF_LIMIT
                                                : FIRST_RESUME_LIMIT))
            begin
              // Too late to resume; stay silent until deactivated
              state       <= ST_INHIBIT;
              o_inhibited <= 1'b1;
            end
          end
          ST_WAIT_LINK:
          begin
            if (link_on_s)
            begin
              state       <= ST_SEND;
              tx_type     <= FRAME_SYNC;
              been_active <= 1'b1;
              timer       <= TIMER_RESET;
            end
            else if (timer_at(timer, SLAVE_DETECT_LIMIT))
            begin
              o_slave_current_signal <= 1'b0;
              o_inhibited            <= 1'b1;
              state                  <= ST_INHIBIT;
            end
          end
          ST_SEND:
          begin
            tx_tgl       <= ~tx_tgl;
            last_type    <= tx_type;
            tx_with_info <= ~subsequent;
            state        <= ST_WAIT_ACK;
          end
          ST_WAIT_ACK:
          begin
            if (ack_evt)
              state <= ST_LISTEN;
            else if (timer_at(timer, POWER_REPLY_LIMIT))
              o_reply_late <= 1'b1;
          end
          ST_LISTEN:
          begin
            // Only a correct power frame is answered
            if (rx_evt && rx_ok_l && rx_type_l == FRAME_POWER)
            begin
              tx_type <= rx_repeat_l ? last_type : FRAME_READY;
              state   <= ST_SEND;
              timer   <= TIMER_RESET;
            end
          end
          ST_INHIBIT:
          begin
            // Ignore the frontend until the contact is deactivated
            state <= ST_INHIBIT;
          end
          default:
          begin
            state <= ST_OFF;
          end
        endcase
      end
    end
  end

  assign o_subsequent = subsequent;

  // Received frame fields held in the link domain beside the event toggle;
  // a second frame before the core has taken the first would overwrite it
  always_ff @(posedge i_link_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rx_tgl      <= 1'b0;
      rx_ok_l     <= 1'b0;
      rx_type_l   <= TYPE_RESET;
      rx_repeat_l <= 1'b0;
    end
    else if (i_rx_valid)
    begin
      rx_tgl      <= ~rx_tgl;
      rx_ok_l     <= i_rx_ok;
      rx_type_l   <= i_rx_type;
      rx_repeat_l <= i_rx_repeat_bit;
    end
  end

  // Frame requests out and transmit completion back, link domain
  always_ff @(posedge i_link_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_seen        <= 1'b0;
      ack_tgl        <= 1'b0;
      o_tx_start     <= 1'b0;
      o_tx_type      <= TYPE_RESET;
      o_tx_with_info <= 1'b0;
    end
    else
    begin
      o_tx_start <= tx_sync != tx_seen;
      tx_seen    <= tx_sync;
      if (tx_sync != tx_seen)
      begin
        // Core fields are stable since the toggle left two edges ago
        o_tx_type      <= last_type;
        o_tx_with_info <= tx_with_info;
      end
      if (i_tx_done)
        ack_tgl <= ~ack_tgl;
    end
  end

  // Dropping the voltage releases the current signal in the next cycle
  volt_drop_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (!mv_s && i_core_en) |=> (!o_slave_current_signal && state == ST_OFF))
    else $error("current signal not released on voltage drop");

  // Ready card resumes in the next cycle
  resume_now_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == ST_WAIT_RESUME && i_card_ready && mv_s && supply_s && i_core_en)
    |=> (o_slave_current_signal && state == ST_WAIT_LINK))
    else $error("card did not resume when ready");

  // Resume wait never outlives its window
  resume_window_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == ST_WAIT_RESUME) |->
    (timer <= (subsequent ? RESUME_FROM_OFF_LIMIT : FIRST_RESUME_LIMIT)))
    else $error("resume window exceeded");

  // Link-on wait ends by the detect timeout
  detect_timeout_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == ST_WAIT_LINK && !link_on_s && mv_s && supply_s && i_core_en &&
     timer >= SLAVE_DETECT_LIMIT)
    |=> (!o_slave_current_signal && o_inhibited))
    else $error("current signal not dropped after detect timeout");

  // Inhibited card stays mute
  inhibit_mute_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == ST_INHIBIT) |=> $stable(tx_tgl))
    else $error("inhibited card sent a frame");

  // Corrupted frames get no reply
  no_reply_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == ST_LISTEN && rx_evt && !rx_ok_l) |=> (state != ST_SEND))
    else $error("reply to corrupted frame");

  // Repeat request resends last frame, else ready
  power_answer_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == ST_LISTEN && rx_evt && rx_ok_l && rx_type_l == FRAME_POWER &&
     mv_s && supply_s && i_core_en)
    |=> (state == ST_SEND &&
         tx_type == ($past(rx_repeat_l) ? $past(last_type) : FRAME_READY)))
    else $error("wrong answer to power frame");

  // Info field follows initial or subsequent activation
  info_field_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (tx_tgl != $past(tx_tgl)) |-> (tx_with_info == !subsequent))
    else $error("info field presence wrong");

  // Link on leads to the sync frame request
  first_sync_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == ST_WAIT_LINK && link_on_s && mv_s && supply_s && i_core_en)
    |=> (state == ST_SEND && tx_type == FRAME_SYNC))
    else $error("no sync frame after link on");

endmodule

// *** design/level_sync.sv ***
// Two flip-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
module level_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  // Clock and reset of the receiving domain
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // Levels from the foreign domain and their synchronised copies
  input  wire logic [WIDTH-1:0] i_async,
  output      logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stage1 <= '0;
      o_sync <= '0;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// *** test/frontend_model.sv ***
// Behavioural frontend model: sends activation frames and confirms card frames
`timescale 1ns/10ps
module frontend_model
(
  // Link clock and card transmit request
  input  wire logic       i_link_clk,
  input  wire logic       i_tx_start,
  // Bench control: hold back the send confirmation
  input  wire logic       i_stall,
  // Frame port towards the card
  output      logic       o_rx_valid,
  output      logic       o_rx_ok,
  output      logic [1:0] o_rx_type,
  output      logic       o_rx_repeat_bit,
  output      logic       o_tx_done
);
  int unsigned done_cnt;

  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_ok = 1'b0;
    o_rx_type = 2'h3;
    o_rx_repeat_bit = 1'b0;
    o_tx_done = 1'b0;
    done_cnt = 0;
  end

  // Confirm a card frame three link cycles after its start, later while stalled
  always @(posedge i_link_clk)
  begin
    o_tx_done <= #1 (i_tx_start !== 1'b1 && done_cnt == 1 && !i_stall);
    if (i_tx_start === 1'b1)
      done_cnt <= 3;
    else if (done_cnt > 1)
      done_cnt <= done_cnt - 1;
    else if (done_cnt == 1 && !i_stall)
      done_cnt <= 0;
  end

  // One frame end; fields invert afterwards so stale values are never reused
  task automatic send(input logic ok, input logic [1:0] kind, input logic rep);
    @(posedge i_link_clk);
    #1;
    o_rx_valid = 1'b1;
    o_rx_ok = ok;
    o_rx_type = kind;
    o_rx_repeat_bit = rep;
    @(posedge i_link_clk);
    #1;
    o_rx_valid = 1'b0;
    o_rx_ok = ~ok;
    o_rx_type = ~kind;
    o_rx_repeat_bit = ~rep;
  endtask
endmodule

// *** test/single_wire_link_activation_bench.sv ***
// Self-checking bench for the card-side activation sequencer
`timescale 1ns/10ps
module single_wire_link_activation_bench
  import act_seq_pkg::*;
;
  // Shortened counts keep the run brief
  localparam int unsigned FIRST_LIM  = 70;
  localparam int unsigned OFF_LIM    = 50;
  localparam int unsigned REPLY_LIM  = 200;
  localparam int unsigned DETECT_LIM = 1000;
  localparam int unsigned RAISE_CYC  = 100;

  logic       i_core_clk = 1'b0;
  logic       i_link_clk = 1'b0;
  logic       i_arst_n = 1'b0;
  logic       i_supply_on = 1'b0;
  logic       i_master_voltage_signal = 1'b0;
  logic       i_card_ready = 1'b0;
  logic       i_link_on = 1'b0;
  logic       stall = 1'b0;
  logic       core_en = 1'b1;
  logic       rx_valid, rx_ok, rx_rep, tx_done;
  logic [1:0] rx_type;
  logic       o_slave_current_signal, o_inhibited, o_reply_late, o_subsequent;
  logic       o_tx_start, o_tx_with_info;
  logic [1:0] o_tx_type;
  logic [1:0] tx_type;
  logic       tx_info, seen;
  int         n_fail = 0;
  int         cmp_count = 0;

  card_act_seq #(.FIRST_RESUME_LIMIT(FIRST_LIM), .RESUME_FROM_OFF_LIMIT(OFF_LIM),
    .POWER_REPLY_LIMIT(REPLY_LIM), .SLAVE_DETECT_LIMIT(DETECT_LIM)) uut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_core_en(core_en),
    .i_supply_on(i_supply_on), .i_master_voltage_signal(i_master_voltage_signal),
    .i_card_ready(i_card_ready), .o_slave_current_signal(o_slave_current_signal),
    .o_inhibited(o_inhibited), .o_reply_late(o_reply_late), .o_subsequent(o_subsequent),
    .i_link_clk(i_link_clk), .i_link_on(i_link_on), .i_rx_valid(rx_valid),
    .i_rx_ok(rx_ok), .i_rx_type(rx_type), .i_rx_repeat_bit(rx_rep), .i_tx_done(tx_done),
    .o_tx_start(o_tx_start), .o_tx_type(o_tx_type), .o_tx_with_info(o_tx_with_info));

  frontend_model fm (.i_link_clk(i_link_clk), .i_tx_start(o_tx_start), .i_stall(stall),
    .o_rx_valid(rx_valid), .o_rx_ok(rx_ok), .o_rx_type(rx_type),
    .o_rx_repeat_bit(rx_rep), .o_tx_done(tx_done));

  // Core clock 100 MHz; link clock 30 ns with an unrelated offset
  initial
    forever #5 i_core_clk = ~i_core_clk;
  initial
  begin
    #7;
    forever #15 i_link_clk = ~i_link_clk;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic set_link(input logic v);
    @(posedge i_link_clk);
    #1;
    i_link_on = v;
  endtask

  // Bounded wait for a transmit request, capturing what it asks for
  task automatic wait_tx(input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++)
    begin
      @(posedge i_link_clk);
      if (o_tx_start === 1'b1)
      begin
        seen = 1'b1;
        tx_type = o_tx_type;
        tx_info = o_tx_with_info;
      end
    end
  endtask

  // Frontend frame after a gap, then judge the card's answer
  task automatic reply(input logic ok, input logic rep, input logic exp_seen,
                       input logic [1:0] exp_type, input logic exp_info);
    repeat (12) @(posedge i_link_clk);
    fm.send(ok, FRAME_POWER, rep);
    wait_tx(40);
    chk("reply seen", exp_seen, seen);
    if (exp_seen)
    begin
      chk("reply type", exp_type, tx_type);
      chk("reply info", exp_info, tx_info);
    end
  endtask

  // Supply first, contact raised only after the raise delay
  task automatic power_up(input logic ready);
    i_card_ready = ready;
    i_supply_on = 1'b1;
    cyc(RAISE_CYC);
    i_master_voltage_signal = 1'b1;
    cyc(5);
  endtask

  // Contact dropped before the supply goes
  task automatic power_down();
    set_link(1'b0);
    i_master_voltage_signal = 1'b0;
    cyc(5);
    i_supply_on = 1'b0;
    cyc(5);
  endtask

  task automatic t_initial();
    power_up(1'b1);
    chk("current", 2'h1, o_slave_current_signal);
    chk("subsequent", 2'h0, o_subsequent);
    set_link(1'b1);
    wait_tx(20);
    chk("sync seen", 2'h1, seen);
    chk("sync type", FRAME_SYNC, tx_type);
    chk("sync info", 2'h1, tx_info);
    reply(1'b1, 1'b1, 1'b1, FRAME_SYNC, 1'b1);
    reply(1'b1, 1'b0, 1'b1, FRAME_READY, 1'b1);
    reply(1'b1, 1'b1, 1'b1, FRAME_READY, 1'b1);
    reply(1'b0, 1'b0, 1'b0, FRAME_READY, 1'b1);
    // A frame that is not a power frame is never answered
    repeat (12) @(posedge i_link_clk);
    fm.send(1'b1, FRAME_READY, 1'b0);
    wait_tx(40);
    chk("ready ignored", 2'h0, seen);
    chk("reply late", 2'h0, o_reply_late);
    $display("initial activation done");
  endtask

  task automatic t_subsequent();
    set_link(1'b0);
    i_master_voltage_signal = 1'b0;
    cyc(6);
    chk("current low", 2'h0, o_slave_current_signal);
    i_master_voltage_signal = 1'b1;
    cyc(6);
    chk("subsequent", 2'h1, o_subsequent);
    chk("current", 2'h1, o_slave_current_signal);
    set_link(1'b1);
    wait_tx(20);
    chk("sync seen", 2'h1, seen);
    chk("sync info", 2'h0, tx_info);
    reply(1'b1, 1'b1, 1'b1, FRAME_SYNC, 1'b0);
    // Frontend is satisfied now; the card must not send on its own
    wait_tx(40);
    chk("idle", 2'h0, seen);
    $display("subsequent activation done");
  endtask

  task automatic t_no_ready();
    power_down();
    power_up(1'b0);
    chk("subsequent", 2'h0, o_subsequent);
    cyc(FIRST_LIM - 12);
    chk("inhibit early", 2'h0, o_inhibited);
    // Clock enable low freezes the window count
    core_en = 1'b0;
    cyc(30);
    chk("inhibit frozen", 2'h0, o_inhibited);
    core_en = 1'b1;
    cyc(20);
    chk("inhibit", 2'h1, o_inhibited);
    i_card_ready = 1'b1;
    cyc(6);
    chk("late resume", 2'h0, o_slave_current_signal);
    $display("missed resume done");
  endtask

  task automatic t_no_link();
    power_down();
    power_up(1'b1);
    cyc(DETECT_LIM - 30);
    chk("current held", 2'h1, o_slave_current_signal);
    cyc(40);
    chk("current dropped", 2'h0, o_slave_current_signal);
    chk("inhibit", 2'h1, o_inhibited);
    set_link(1'b1);
    wait_tx(20);
    chk("mute", 2'h0, seen);
    $display("missed link-on done");
  endtask

  task automatic t_late();
    power_down();
    power_up(1'b1);
    set_link(1'b1);
    wait_tx(20);
    chk("sync seen", 2'h1, seen);
    // Let the sync frame be confirmed before holding back the reply's confirmation
    repeat (6) @(posedge i_link_clk);
    #1;
    stall = 1'b1;
    reply(1'b1, 1'b0, 1'b1, FRAME_READY, 1'b1);
    cyc(REPLY_LIM + 20);
    chk("reply late", 2'h1, o_reply_late);
    stall = 1'b0;
    power_down();
    power_up(1'b1);
    chk("late cleared", 2'h0, o_reply_late);
    $display("late reply done");
  endtask

  // Watchdog well beyond the expected run time
  initial
  begin
    #500000;
    n_fail++;
    $display("Error watchdog expected finish seen hang");
    stop_test();
  end

  initial
  begin
    #58;
    i_arst_n = 1'b1;
    cyc(5);
    t_initial();
    t_subsequent();
    t_no_ready();
    t_no_link();
    t_late();
    stop_test();
  end
endmodule
